// *** hw/rwpc_pkg.sv ***
// Register map, field positions and timing constants of the reset supervisor
package rwpc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int          ADDR_W   = 12;
    localparam int          DATA_W   = 32;
    localparam logic [7:0]  RD_ZERO  = 8'h00;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_PWR   = 8'h87;
    localparam logic [7:0]  IDX_CLK   = 8'h8e;
    localparam logic [7:0]  IDX_RSD   = 8'h8f;
    localparam logic [7:0]  IDX_CAUSE = 8'h94;
    localparam logic [7:0]  IDX_FLT   = 8'ha6;
    localparam logic [7:0]  IDX_PIN   = 8'hae;
    localparam logic [7:0]  IDX_BOOT  = 8'hb7;
    localparam logic [7:0]  IDX_WDC   = 8'hd8;
    localparam logic [7:0]  IDX_TA    = 8'heb;
    localparam logic [7:0]  IDX_KEY   = 8'hef;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  RST_PWR  = 8'h00;
    localparam logic [7:0]  RST_CLK  = 8'h01;
    localparam logic [7:0]  RST_RSD  = 8'h10;
    localparam logic [7:0]  RST_ZERO = 8'h00;
    localparam logic [7:0]  RST_BOOT = 8'hff;

    // ==========================================================
    // Field positions
    localparam int PIN_LVR_OFF   = 7;
    localparam int PIN_AUD_N_OFF = 4;
    localparam int PIN_CLK_OUT   = 2;
    localparam int PIN_CMP_OFF   = 1;
    localparam int PIN_P4_HYS    = 0;
    localparam int BOOT_LVSEL    = 5;
    localparam int BOOT_PIN_BOOT_STATE_PICK    = 1;
    localparam int BOOT_UNLOCK   = 0;
    localparam int WDC_IRQ       = 3;
    localparam int WDC_CAUSED    = 2;
    localparam int WDC_ALLOW     = 1;
    localparam int WDC_RESTART   = 0;
    localparam int WDC_W         = 4;
    localparam int CLK_WD_LO     = 6;
    localparam int CLK_T1M       = 4;
    localparam int CLK_T0M       = 3;
    localparam int PWR_IDLE      = 5;
    localparam int PWR_FWE       = 4;
    localparam int PWR_STOP_RST  = 3;
    localparam int PWR_STOP      = 1;
    localparam int RSD_LOST_CLK  = 1;
    localparam int RSD_ALL_FLASH = 0;
    // Cause register bits
    localparam int CS_LOST_CLK   = 6;
    localparam int CS_STOP       = 5;
    localparam int CS_FLASH      = 4;
    localparam int CS_SW         = 3;
    localparam int CS_WDT        = 2;
    localparam int CS_LVR        = 1;
    localparam int CS_PIN        = 0;
    // Flash fault bit mask: option, last page, flow, address, mass
    localparam logic [7:0]  FLT_MASK = 8'hf4;

    // ==========================================================
    // Unlock codes
    localparam logic [7:0]  KEY_PIN_A = 8'hff;
    localparam logic [7:0]  KEY_PIN_B = 8'h00;
    localparam logic [7:0]  KEY_RSD_A = 8'h4f;
    localparam logic [7:0]  KEY_RSD_B = 8'h72;
    localparam logic [7:0]  KEY_RSD_C = 8'h7a;
    localparam logic [7:0]  KEY_SW_A  = 8'h3c;
    localparam logic [7:0]  KEY_SW_B  = 8'hc3;
    localparam logic [7:0]  TA_A      = 8'haa;
    localparam logic [7:0]  TA_B      = 8'h55;

    // ==========================================================
    // Timing, in system clocks or oscillator ticks
    localparam int          WD_W        = 27;
    localparam logic [26:0] WD_CLOCKS_0 = 27'h0020000;
    localparam logic [26:0] WD_CLOCKS_1 = 27'h0100000;
    localparam logic [26:0] WD_CLOCKS_2 = 27'h0800000;
    localparam logic [26:0] WD_CLOCKS_3 = 27'h4000000;
    localparam logic [11:0] LOST_TICKS  = 12'hfff;
    localparam logic [3:0]  DIV_SLOW    = 4'hc;
    localparam logic [3:0]  DIV_FAST    = 4'h4;

    typedef enum logic [2:0] {
        RWPC_K_IDLE,
        RWPC_K_PIN,
        RWPC_K_RSD1,
        RWPC_K_RSD2
    } rwpc_key_t;

endpackage : rwpc_pkg

// *** hw/rwpc_top.sv ***
// Reset, watchdog and power-mode control block with APB register access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module rwpc_top
    import rwpc_pkg::*;
#(
    parameter logic [26:0] WD_TIMEOUT_0 = WD_CLOCKS_0,
    parameter logic [26:0] WD_TIMEOUT_1 = WD_CLOCKS_1,
    parameter logic [26:0] WD_TIMEOUT_2 = WD_CLOCKS_2,
    parameter logic [26:0] WD_TIMEOUT_3 = WD_CLOCKS_3
) (
    // Clock and power-on reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Reset sources and monitors
    input  wire logic [7:0]        boot_option_strap,
    input  wire logic              reset_pin_event,
    input  wire logic              lvr_trip,
    input  wire logic              wake_event,
    input  wire logic              xtal_selected,
    input  wire logic              internal_oscillator_tick,
    input  wire logic              system_clock_seen,
    input  wire logic [4:0]        flash_fault_hit,
    input  wire logic              audio_enabled,
    // Chip controls
    output logic                   chip_reset,
    output logic                   low_voltage_reset_off,
    output logic                   low_voltage_threshold_pick,
    output logic                   pin_boot_state_pick,
    output logic                   code_unlocked,
    output logic                   audio_pos_drive,
    output logic                   audio_neg_drive,
    output logic                   sysclock_pin_out,
    output logic                   compare_pins_off,
    output logic                   port4_hysteresis_off,
    output logic                   timer0_tick,
    output logic                   timer1_tick,
    output logic                   core_idle,
    output logic                   stop_mode,
    output logic                   flash_write_allow
);

    // ==========================================================
    // Bus decode
    logic [7:0] pwr_reg, clk_reg, rsd_reg, cause_reg, flt_reg;
    logic [7:0] pin_reg, boot_reg, ta_reg, key_reg;
    logic [WDC_W-1:0] wdc_reg;
    logic       pready_reg, pslverr_reg;
    logic [7:0] rdata_reg;

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == IDX_PWR) || (idx == IDX_CLK) ||
                    (idx == IDX_RSD) || (idx == IDX_CAUSE) ||
                    (idx == IDX_FLT) || (idx == IDX_PIN) ||
                    (idx == IDX_BOOT) || (idx == IDX_WDC) ||
                    (idx == IDX_TA) || (idx == IDX_KEY);
    endfunction : is_mapped

    wire       aligned  = (paddr[1:0] == 2'b00) &&
                          (paddr[ADDR_W-1:10] == '0);
    wire [7:0] idx      = paddr[9:2];
    wire       hit      = aligned && is_mapped(idx);
    wire       setup    = psel && !penable && !pready_reg;
    wire       access   = psel && penable && pready_reg;
    wire       wr       = access && pwrite && hit;
    wire [7:0] wd       = pwdata[7:0];
    wire       wr_pwr   = wr && (idx == IDX_PWR);
    wire       wr_clk   = wr && (idx == IDX_CLK);
    wire       wr_rsd   = wr && (idx == IDX_RSD);
    wire       wr_cause = wr && (idx == IDX_CAUSE);
    wire       wr_flt   = wr && (idx == IDX_FLT);
    wire       wr_pin   = wr && (idx == IDX_PIN);
    wire       wr_wdc   = wr && (idx == IDX_WDC);
    wire       wr_ta    = wr && (idx == IDX_TA);
    wire       wr_key   = wr && (idx == IDX_KEY);

    wire [7:0] rd_mux =
        (idx == IDX_PWR)   ? pwr_reg   :
        (idx == IDX_CLK)   ? clk_reg   :
        (idx == IDX_RSD)   ? rsd_reg   :
        (idx == IDX_CAUSE) ? cause_reg :
        (idx == IDX_FLT)   ? flt_reg   :
        (idx == IDX_PIN)   ? pin_reg   :
        (idx == IDX_BOOT)  ? boot_reg  :
        (idx == IDX_WDC)   ? {4'h0, wdc_reg} :
        (idx == IDX_TA)    ? ta_reg    :
        (idx == IDX_KEY)   ? key_reg   : RD_ZERO;

    // Zero-wait slave: ready in the first access cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            rdata_reg   <= RST_ZERO;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !hit;
            rdata_reg   <= (setup && !pwrite && hit) ? rd_mux : RST_ZERO;
        end
    end

    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = {{(DATA_W-8){1'b0}}, rdata_reg};

    // ==========================================================
    // Unlock sequences
    rwpc_key_t key_reg_st, key_next_st;
    logic      pin_open_reg, rsd_open_reg, sw_armed_reg;
    logic      ta_half_reg, ta_open_reg;

    always_comb begin
        key_next_st = key_reg_st;
        if (wr_key) begin
            key_next_st = RWPC_K_IDLE;
            if (wd == KEY_PIN_A)
                key_next_st = RWPC_K_PIN;
            else if (wd == KEY_RSD_A)
                key_next_st = RWPC_K_RSD1;
            else if (key_reg_st == RWPC_K_RSD1 && wd == KEY_RSD_B)
                key_next_st = RWPC_K_RSD2;
        end
    end

    // FF then 00 opens one pin write
    wire pin_key  = wr_key && key_reg_st == RWPC_K_PIN && wd == KEY_PIN_B;
    // 4F, 72, 7A opens one disable write
    wire rsd_key  = wr_key && key_reg_st == RWPC_K_RSD2 && wd == KEY_RSD_C;
    // 3c arms, c3 fires, spacing free
    wire sw_fire  = wr_key && sw_armed_reg && wd == KEY_SW_B;
    wire pin_take = wr_pin && pin_open_reg;
    wire rsd_take = wr_rsd && rsd_open_reg;
    // exact aa then 55 on consecutive writes
    wire ta_pass  = wr_ta && ta_half_reg && wd == TA_B;
    // the very next write must be the watchdog register
    wire wdc_take = wr_wdc && ta_open_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_reg_st   <= RWPC_K_IDLE;
            pin_open_reg <= 1'b0;
            rsd_open_reg <= 1'b0;
            sw_armed_reg <= 1'b0;
            ta_half_reg  <= 1'b0;
            ta_open_reg  <= 1'b0;
        end else begin
            key_reg_st   <= key_next_st;
            pin_open_reg <= pin_key || (pin_open_reg && !wr_pin);
            rsd_open_reg <= rsd_key || (rsd_open_reg && !wr_rsd);
            if (wr_key)
                sw_armed_reg <= (wd == KEY_SW_A) ||
                                (sw_armed_reg && wd != KEY_SW_B);
            if (wr) begin
                ta_half_reg <= wr_ta && wd == TA_A;
                ta_open_reg <= ta_pass;
            end
        end
    end

    // ==========================================================
    // Watchdog
    logic [WD_W-1:0] wd_cnt_reg;
    wire  [1:0]      wd_code = clk_reg[CLK_WD_LO+1:CLK_WD_LO];
    wire  [WD_W-1:0] wd_limit = (wd_code == 2'b00) ? WD_TIMEOUT_0 :
                                (wd_code == 2'b01) ? WD_TIMEOUT_1 :
                                (wd_code == 2'b10) ? WD_TIMEOUT_2 :
                                                     WD_TIMEOUT_3;
    wire wd_expire  = wd_cnt_reg == wd_limit - 27'h1;
    wire wd_restart = wdc_take && wd[WDC_RESTART];
    wire wd_reset   = wd_expire && wdc_reg[WDC_ALLOW];

    // ==========================================================
    // Lost system clock monitor
    logic [11:0] lost_cnt_reg;
    // crystal absent beyond 4095 oscillator ticks
    wire lost_clk = xtal_selected && internal_oscillator_tick && !system_clock_seen &&
                    lost_cnt_reg == LOST_TICKS;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            lost_cnt_reg <= 12'h000;
        else if (system_clock_seen || !xtal_selected || lost_clk)
            lost_cnt_reg <= 12'h000;
        else if (internal_oscillator_tick)
            lost_cnt_reg <= lost_cnt_reg + 12'h001;
    end

    // ==========================================================
    // Reset source collection
    wire [7:0] flt_hit  = {flash_fault_hit[4:1], 1'b0,
                           flash_fault_hit[0], 2'b00};
    // per-cause and global flash reset suppression
    wire [7:0] flt_go   = rsd_reg[RSD_ALL_FLASH] ? RST_ZERO :
                          (flt_hit & ~rsd_reg & FLT_MASK);
    wire lost_go  = lost_clk && !rsd_reg[RSD_LOST_CLK];
    // low-voltage reset obeys the off bit
    wire lvr_go   = lvr_trip && !pin_reg[PIN_LVR_OFF];
    wire stop_wk  = wake_event && pwr_reg[PWR_STOP];
    // stop wake may pass through reset
    wire stop_go  = stop_wk && pwr_reg[PWR_STOP_RST];
    wire [7:0] cause_set = {1'b0, lost_go, stop_go, |flt_go, sw_fire,
                            wd_reset, lvr_go, reset_pin_event};
    wire any_rst  = |cause_set;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            wd_cnt_reg <= '0;
        else if (wd_restart || wd_expire || any_rst)
            wd_cnt_reg <= '0;
        else
            wd_cnt_reg <= wd_cnt_reg + 27'h1;
    end

    // ==========================================================
    // Registers; hardware set wins over software clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cause_reg <= RST_ZERO;
            flt_reg   <= RST_ZERO;
        end else begin
            // untouched by chip resets, cleared by power-on or by a software write
            cause_reg <= (wr_cause ? wd : cause_reg) | cause_set;
            flt_reg   <= ((wr_flt ? wd : flt_reg) | flt_go) & FLT_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wdc_reg <= '0;
        end else begin
            if (wdc_take)
                wdc_reg <= wd[WDC_W-1:0];
            else
                wdc_reg[WDC_RESTART] <= 1'b0;
            // irq flag set on expiry, caused flag on watchdog reset, set beats write
            if (wd_expire)
                wdc_reg[WDC_IRQ] <= 1'b1;
            if (wd_reset)
                wdc_reg[WDC_CAUSED] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg <= RST_ZERO;
            rsd_reg <= RST_RSD;
            clk_reg <= RST_CLK;
            ta_reg  <= RST_ZERO;
            key_reg <= RST_ZERO;
        end else begin
            if (pin_take)
                pin_reg <= wd;
            if (rsd_take)
                rsd_reg <= wd;
            if (wr_clk)
                clk_reg <= wd;
            if (wr_ta)
                ta_reg <= wd;
            if (wr_key)
                key_reg <= wd;
        end
    end

    // Idle and stop leave on wake or on any chip reset, unless the power register is written in that cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            pwr_reg <= RST_PWR;
        else if (wr_pwr)
            pwr_reg <= wd;
        else if (wake_event || any_rst) begin
            pwr_reg[PWR_IDLE] <= 1'b0;
            pwr_reg[PWR_STOP] <= 1'b0;
        end
    end

    // Strap is sampled once after release, never under reset
    logic strap_done_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            boot_reg       <= RST_BOOT;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            boot_reg       <= boot_option_strap;
        end
    end

    // ==========================================================
    // Timer prescalers
    logic [3:0] div_cnt_reg [2];
    logic       tick_reg [2];
    wire  [1:0] fast_pick = {clk_reg[CLK_T1M], clk_reg[CLK_T0M]};

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_prescale
            // divide by 12 or by 4
            wire [3:0] div_top = fast_pick[t] ? DIV_FAST : DIV_SLOW;
            wire       wrap    = div_cnt_reg[t] >= div_top - 4'h1;
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    div_cnt_reg[t] <= 4'h0;
                    tick_reg[t]    <= 1'b0;
                end else begin
                    div_cnt_reg[t] <= wrap ? 4'h0 : div_cnt_reg[t] + 4'h1;
                    tick_reg[t]    <= wrap;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Registered outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chip_reset      <= 1'b0;
            audio_pos_drive <= 1'b0;
            audio_neg_drive <= 1'b0;
        end else begin
            chip_reset      <= any_rst;
            // negative audio pin dropped on request
            audio_pos_drive <= audio_enabled;
            audio_neg_drive <= audio_enabled && !pin_reg[PIN_AUD_N_OFF];
        end
    end

    assign low_voltage_reset_off      = pin_reg[PIN_LVR_OFF];
    // threshold choice, 0 high level, 1 low level
    assign low_voltage_threshold_pick = boot_reg[BOOT_LVSEL];
    assign pin_boot_state_pick        = boot_reg[BOOT_PIN_BOOT_STATE_PICK];
    assign code_unlocked              = boot_reg[BOOT_UNLOCK];
    assign sysclock_pin_out           = pin_reg[PIN_CLK_OUT];
    assign compare_pins_off           = pin_reg[PIN_CMP_OFF];
    assign port4_hysteresis_off       = pin_reg[PIN_P4_HYS];
    assign timer0_tick                = tick_reg[0];
    assign timer1_tick                = tick_reg[1];
    assign core_idle                  = pwr_reg[PWR_IDLE];
    assign stop_mode                  = pwr_reg[PWR_STOP];
    assign flash_write_allow          = pwr_reg[PWR_FWE];

endmodule : rwpc_top

// *** bench/rwpc_checker.sv ***
// Port-level timing checks of the reset supervisor
`timescale 1ns/1ps
module rwpc_checker
    import rwpc_pkg::*;
(
    // Clock, reset and bus
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Events and controls
    input wire logic              lvr_trip,
    input wire logic              wake_event,
    input wire logic              chip_reset,
    input wire logic              low_voltage_reset_off,
    input wire logic              audio_pos_drive,
    input wire logic              audio_neg_drive,
    input wire logic              timer0_tick,
    input wire logic              timer1_tick,
    input wire logic              core_idle,
    input wire logic              stop_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Assertions
    bus_answer_a: assert property (
        psel && !penable |=> pready) else $error("no answer");
    err_ready_a: assert property (
        pslverr |-> pready) else $error("stray error");
    rd_upper_a: assert property (
        pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
    lvr_reset_a: assert property (
        lvr_trip && !low_voltage_reset_off |-> ##[1:2] chip_reset)
        else $error("missed lvr reset");
    audio_pair_a: assert property (
        audio_neg_drive |-> audio_pos_drive) else $error("audio pair");
    tick0_gap_a: assert property (
        timer0_tick |=> !timer0_tick [*3]) else $error("timer0 gap");
    tick1_gap_a: assert property (
        timer1_tick |=> !timer1_tick [*3]) else $error("timer1 gap");
    wake_clear_a: assert property (
        wake_event && stop_mode && !(psel && penable)
        |=> !stop_mode && !core_idle) else $error("wake kept stop");
    reset_pulse_a: assert property (
        chip_reset |=> !chip_reset) else $error("long reset");
    cover property (chip_reset);
    cover property (pslverr);
    cover property (wake_event && stop_mode);
endmodule : rwpc_checker
bind rwpc_top rwpc_checker rwpc_checker_i (.*);

// *** bench/tb_top.sv ***
// Self-checking bench of the reset supervisor
`timescale 1ns/1ps
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    error_cnt++; $display("wrong value %s exp %0h got %0h", n, e, g); \
    end end
module tb_top;
    import rwpc_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, er, pk, rk;
    logic reset_pin_event, lvr_trip, wake_event, xtal_selected, internal_oscillator_tick;
    logic system_clock_seen, audio_enabled, chip_reset, code_unlocked;
    logic low_voltage_reset_off, low_voltage_threshold_pick;
    logic pin_boot_state_pick, audio_pos_drive, audio_neg_drive;
    logic sysclock_pin_out, compare_pins_off, port4_hysteresis_off;
    logic timer0_tick, timer1_tick, core_idle, stop_mode, flash_write_allow;
    logic [4:0]        flash_fault_hit;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [7:0]        boot_option_strap, rd, d, m[256];
    logic [15:0]       kq;
    logic [7:0]        rs[2] = '{8'h20, 8'h01};
    int                fb[5] = '{2, 4, 5, 6, 7};
    int                error_cnt, compares, n, a, b, tq;

    rwpc_top #(.WD_TIMEOUT_0(27'h100), .WD_TIMEOUT_1(27'h200),
        .WD_TIMEOUT_2(27'h400), .WD_TIMEOUT_3(27'h800)) rwpc_top_i (.*);

    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end

    task automatic test_done;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // ==========================================================
    // Bus master and register model
    task automatic bus(input logic w, input logic [7:0] x, v);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w;
        paddr <= {2'b00, x, 2'b00}; pwdata <= {24'h0, v};
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata[7:0]; er = pslverr;
        psel <= 0; penable <= 0;
    endtask : bus

    task automatic wr(input logic [7:0] x, v);
        logic ok;
        bus(1'b1, x, v);
        ok = !(x == IDX_BOOT || (x == IDX_PIN && !pk)
            || (x == IDX_RSD && !rk) || (x == IDX_WDC && tq != 2));
        if (x == IDX_PIN) pk = 0;
        if (x == IDX_RSD) rk = 0;
        if (x == IDX_KEY) begin
            pk = pk || (kq[7:0] == KEY_PIN_A && v == KEY_PIN_B);
            rk = rk || (kq == {KEY_RSD_A, KEY_RSD_B} && v == KEY_RSD_C);
            kq = {kq[7:0], v};
        end
        tq = x != IDX_TA ? 0 : v == TA_A ? 1 : (v == TA_B && tq == 1) ? 2 : 0;
        if (ok) m[x] = v & (x == IDX_WDC ? 8'h0e : x == IDX_FLT ? FLT_MASK : 8'hff);
    endtask : wr

    task automatic chk(input logic [7:0] x, k);
        bus(1'b0, x, 8'h00);
        `CK("register", m[x] & k, rd & k)
    endtask : chk

    // Reset pulses seen in the next four cycles
    task automatic ev(input int e);
        n = 0;
        repeat (4) begin @(posedge mclk); n += (chip_reset === 1'b1); end
        `CK("chip_reset", e, n)
    endtask : ev

    task automatic ta_wdc(input logic [7:0] v);
        wr(IDX_TA, TA_A); wr(IDX_TA, TA_B); wr(IDX_WDC, v);
    endtask : ta_wdc

    initial begin
        #2_000_000;
        error_cnt++;
        test_done;
    end

    // ==========================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, flash_fault_hit} = '0;
        {reset_pin_event, lvr_trip, wake_event, xtal_selected} = '0;
        {internal_oscillator_tick, system_clock_seen, audio_enabled, pk, rk} = '0;
        rst_n = 0; error_cnt = 0; compares = 0; tq = 0; kq = 0;
        void'($urandom(32'h55d2));
        boot_option_strap = $urandom;
        foreach (m[i]) m[i] = 8'h00;
        m[IDX_CLK] = RST_CLK; m[IDX_RSD] = RST_RSD;
        m[IDX_BOOT] = boot_option_strap;
        repeat (4) @(posedge mclk);
        rst_n <= 1;
        // Irq flag may already tick, so it is masked here
        foreach (m[i]) if (m[i] !== 8'hxx && i inside {IDX_PWR, IDX_CLK,
            IDX_RSD, IDX_CAUSE, IDX_FLT, IDX_PIN, IDX_BOOT, IDX_WDC,
            IDX_TA, IDX_KEY}) chk(i, i == IDX_WDC ? 8'h07 : 8'hff);
        `CK("thr", boot_option_strap[5], low_voltage_threshold_pick)
        `CK("pin_boot_state_pick", boot_option_strap[1], pin_boot_state_pick)
        `CK("lock", boot_option_strap[0], code_unlocked)
        wr(IDX_BOOT, ~boot_option_strap); chk(IDX_BOOT, 8'hff);
        bus(1'b0, 8'h00, 8'h00); `CK("slverr", 1'b1, er)
        for (int j = 0; j < 2; j++) begin
            audio_enabled <= j[0];
            d = ($urandom & 8'h17) | 8'h01 | (j ? 8'h80 : 8'h00);
            wr(IDX_PIN, d); chk(IDX_PIN, 8'h97);
            wr(IDX_KEY, KEY_PIN_A); wr(IDX_KEY, 8'h01);
            wr(IDX_KEY, KEY_PIN_B); wr(IDX_PIN, d); chk(IDX_PIN, 8'h97);
            wr(IDX_KEY, KEY_PIN_A); wr(IDX_KEY, KEY_PIN_B); wr(IDX_PIN, d);
            chk(IDX_PIN, 8'h97);
            `CK("lvr_off", d[7], low_voltage_reset_off)
            `CK("clk_out", d[2], sysclock_pin_out)
            `CK("cmp_off", d[1], compare_pins_off)
            `CK("aneg", j[0] & !d[4], audio_neg_drive)
            `CK("apos", j[0], audio_pos_drive)
            `CK("p4_hys", d[0], port4_hysteresis_off)
            lvr_trip <= 1; @(posedge mclk); lvr_trip <= 0;
            ev(!d[7]);
        end
        m[IDX_CAUSE][CS_LVR] = 1;
        wr(IDX_RSD, 8'hff);
        for (int r = 0; r < 2; r++) begin
            wr(IDX_KEY, KEY_RSD_A); wr(IDX_KEY, KEY_RSD_B);
            wr(IDX_KEY, KEY_RSD_C); wr(IDX_RSD, rs[r]);
            chk(IDX_RSD, 8'hff); wr(IDX_FLT, 8'h00);
            for (int i = 0; i < 5; i++) begin
                a = !(rs[r][0] | rs[r][fb[i]]);
                flash_fault_hit <= 5'h01 << i; @(posedge mclk);
                flash_fault_hit <= 0; ev(a);
                if (a) begin m[IDX_FLT][fb[i]] = 1; m[IDX_CAUSE][4] = 1; end
            end
            chk(IDX_FLT, 8'hff);
        end
        wr(IDX_KEY, KEY_SW_A); wr(IDX_KEY, 8'h12); wr(IDX_KEY, KEY_SW_B);
        ev(1);
        reset_pin_event <= 1; @(posedge mclk); reset_pin_event <= 0;
        ev(1);
        wr(IDX_PWR, 8'h3a); repeat (2) @(posedge mclk);
        `CK("idle", 1'b1, core_idle)
        `CK("fwe", 1'b1, flash_write_allow)
        `CK("stop", 1'b1, stop_mode)
        wake_event <= 1; @(posedge mclk); wake_event <= 0; ev(1);
        m[IDX_PWR] = 8'h18; chk(IDX_PWR, 8'hff);
        wr(IDX_PWR, 8'h22); wake_event <= 1; @(posedge mclk);
        wake_event <= 0; ev(0);
        m[IDX_PWR] = 8'h00; wr(IDX_WDC, 8'h02); chk(IDX_WDC, 8'h07);
        wr(IDX_TA, TA_A); wr(IDX_PWR, 8'h00); wr(IDX_TA, TA_B);
        wr(IDX_WDC, 8'h02); chk(IDX_WDC, 8'h07);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CLK, {c[1:0], 6'h00}); ta_wdc(8'h03);
            bus(1'b0, IDX_WDC, 8'h00); `CK("restart", 1'b0, rd[0])
            n = 3;
            while (chip_reset !== 1'b1 && n < 3000) begin
                @(posedge mclk); n++;
            end
            `CK("wd_time", 1, n >= (256 << c) && n <= (256 << c) + 3)
            m[IDX_WDC] = 8'h0e; chk(IDX_WDC, 8'h0f);
        end
        wr(IDX_CLK, 8'h00); ta_wdc(8'h01);
        n = 0;
        repeat (300) begin @(posedge mclk); n += (chip_reset === 1'b1); end
        `CK("wd_off", 0, n)
        m[IDX_WDC] = 8'h08; chk(IDX_WDC, 8'h0f);
        for (int t = 0; t < 2; t++) begin
            wr(IDX_CLK, t ? 8'h18 : 8'h00); repeat (30) @(posedge mclk);
            a = 0; b = 0;
            repeat (120) begin
                @(posedge mclk);
                a += (timer0_tick === 1'b1); b += (timer1_tick === 1'b1);
            end
            `CK("t0", t ? 30 : 10, a)
            `CK("t1", t ? 30 : 10, b)
        end
        system_clock_seen <= 1; xtal_selected <= 1; internal_oscillator_tick <= 1;
        @(posedge mclk);
        system_clock_seen <= 0; n = 0;
        while (chip_reset !== 1'b1 && n < 5000) begin @(posedge mclk); n++; end
        `CK("lost", 1, n >= 4094 && n <= 4100)
        xtal_selected <= 0; internal_oscillator_tick <= 0;
        m[IDX_CAUSE] = 8'h7f; chk(IDX_CAUSE, 8'hff);
        test_done;
    end
endmodule : tb_top
